// File: jdtp_port.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - instruction mirror shows current instruction, changed only in UPDATE-IR or TAP_RESET.
// - debug reset low clears all tap state, asynchronously at any time.
// - serial out enable is low exactly while data shifts out.
// - chain number output shows selected chain, changed only in UPDATE-DR.
// - shift data relayed to external chain; chain returns data on input.
// - tap state is sampled onto a 4-bit mirror bus; short-lived states may be skipped.
// - mode select sequences states; serial in feeds, serial out returns data.
// - with IDCODE loaded, the 32-bit id input is shifted out.
module jdtp_port
  import jdtp_pkg::*;
#(
  parameter logic [4:0] EXT_CHAIN = EXT_CHAIN_DEFAULT
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic test_clk,
  input wire logic debug_logic_reset_n,
  input wire logic debug_mode_select,
  input wire logic debug_serial_in,
  input wire logic ext_chain_shift_return,
  input wire logic [ID_W-1:0] id_value_input,
  output logic debug_serial_out,
  output logic serial_out_enable_n,
  output logic ext_chain_shift_out,
  output logic [IR_W-1:0] tap_instruction_mirror,
  output logic [CHAIN_W-1:0] selected_chain_number,
  output logic [3:0] tap_state_mirror
);

  if (EXT_CHAIN == CHAIN_RESET_VAL)
  begin : g_chk
    $error("external chain number must differ from the reset chain");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [4:0] drMsb(input logic [3:0] instr);
    case (instr)
      INSTR_IDCODE: drMsb = MSB_ID;
      INSTR_SCAN_N: drMsb = MSB_CHAIN;
      default: drMsb = MSB_BYPASS;
    endcase
  endfunction : drMsb

  function automatic logic [ID_W-1:0] shiftIn(input logic [ID_W-1:0] cur,
    input logic bitIn, input logic [4:0] msb);
    logic [ID_W-1:0] res;
    res = cur >> 1;
    res[msb] = bitIn;
    shiftIn = res;
  endfunction : shiftIn

  // ****************************************************************
  // tap controller, test clock domain
  // ****************************************************************
  jdtp_state_e tapState;
  jdtp_state_e next_tapState;
  logic [IR_W-1:0] irShift;
  logic [IR_W-1:0] irReg;
  logic [ID_W-1:0] drShift;
  logic [CHAIN_W-1:0] chainReg;
  logic extRelay;
  logic isShift;

  always_comb
  begin
    next_tapState = tapState;
    case (tapState)
      TAP_RESET:
        next_tapState = debug_mode_select ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:
        next_tapState = debug_mode_select ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:
        next_tapState = debug_mode_select ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR:
        next_tapState = debug_mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:
        next_tapState = debug_mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:
        next_tapState = debug_mode_select ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:
        next_tapState = debug_mode_select ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:
        next_tapState = debug_mode_select ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:
        next_tapState = debug_mode_select ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:
        next_tapState = debug_mode_select ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR:
        next_tapState = debug_mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:
        next_tapState = debug_mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:
        next_tapState = debug_mode_select ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:
        next_tapState = debug_mode_select ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:
        next_tapState = debug_mode_select ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:
        next_tapState = debug_mode_select ? TAP_SEL_DR : TAP_IDLE;
      default:
        next_tapState = TAP_RESET;
    endcase
  end

  always_ff @(posedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
      tapState <= TAP_RESET;
    else
      tapState <= next_tapState;
  end

  always_ff @(posedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
    begin
      irShift <= INSTR_IDCODE;
      irReg <= INSTR_IDCODE;
    end
    else if (tapState == TAP_RESET)
      irReg <= INSTR_IDCODE;
    else if (tapState == TAP_CAPTURE_IR)
      irShift <= IR_CAPTURE_VAL;
    else if (tapState == TAP_SHIFT_IR)
      irShift <= {debug_serial_in, irShift[IR_W-1:1]};
    else if (tapState == TAP_UPDATE_IR)
      irReg <= irShift;
  end

  // id captured from the input bus; the integrator holds it static
  always_ff @(posedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
      drShift <= '0;
    else if (tapState == TAP_CAPTURE_DR)
    begin
      if (irReg == INSTR_IDCODE)
        drShift <= id_value_input;
      else if (irReg == INSTR_SCAN_N)
        drShift <= {{(ID_W-CHAIN_W){1'b0}}, chainReg};
      else
        drShift <= '0;
    end
    else if (tapState == TAP_SHIFT_DR)
      drShift <= shiftIn(drShift, debug_serial_in, drMsb(irReg));
  end

  always_ff @(posedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
      chainReg <= CHAIN_RESET_VAL;
    else if (tapState == TAP_UPDATE_DR && irReg == INSTR_SCAN_N)
      chainReg <= drShift[CHAIN_W-1:0];
  end

  assign extRelay = (irReg == INSTR_INTEST) && (chainReg == EXT_CHAIN);
  assign isShift = (tapState == TAP_SHIFT_DR) || (tapState == TAP_SHIFT_IR);

  // ****************************************************************
  // serial outputs, changed on the falling test clock edge
  // ****************************************************************
  // driving on the falling edge gives the debugger half a period of setup
  always_ff @(negedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
    begin
      debug_serial_out <= 1'b0;
      serial_out_enable_n <= 1'b1;
      ext_chain_shift_out <= 1'b0;
    end
    else
    begin
      serial_out_enable_n <= !isShift;
      if (tapState == TAP_SHIFT_IR)
        debug_serial_out <= irShift[0];
      else if (tapState == TAP_SHIFT_DR && extRelay)
        debug_serial_out <= ext_chain_shift_return;
      else if (tapState == TAP_SHIFT_DR)
        debug_serial_out <= drShift[0];
      if (tapState == TAP_SHIFT_DR && extRelay)
        ext_chain_shift_out <= debug_serial_in;
    end
  end

  // ****************************************************************
  // mirror crossing: request/acknowledge handshake into core_clk
  // ****************************************************************
  // the mirror samples the tap state only when the previous word has been
  // taken, so it may skip short-lived states; it never shows a torn word
  logic [IR_W+CHAIN_W+3:0] hold;
  logic req;
  logic ackMeta;
  logic ackSync;
  logic reqMeta;
  logic reqSync;
  logic ack;

  always_ff @(posedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
    begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
    end
    else
    begin
      ackMeta <= ack;
      ackSync <= ackMeta;
    end
  end

  always_ff @(posedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
    begin
      req <= 1'b0;
      // reset word matches the mirrors' own reset values
      hold <= {INSTR_IDCODE, CHAIN_RESET_VAL, TAP_RESET};
    end
    else if (req == ackSync)
    begin
      hold <= {irReg, chainReg, tapState};
      req <= !req;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reqMeta <= 1'b0;
      reqSync <= 1'b0;
    end
    else
    begin
      reqMeta <= req;
      reqSync <= reqMeta;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      tap_instruction_mirror <= INSTR_IDCODE;
      selected_chain_number <= CHAIN_RESET_VAL;
      tap_state_mirror <= TAP_RESET;
    end
    else if (reqSync != ack)
    begin
      ack <= reqSync;
      tap_instruction_mirror <= hold[IR_W+CHAIN_W+3:CHAIN_W+4];
      selected_chain_number <= hold[CHAIN_W+3:4];
      tap_state_mirror <= hold[3:0];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // the reset may fall while the test clock stands still, so the first edge
  // after release compares against values from before the reset
  logic firstEdge;

  always_ff @(posedge test_clk or negedge debug_logic_reset_n)
  begin
    if (!debug_logic_reset_n)
      firstEdge <= 1'b1;
    else
      firstEdge <= 1'b0;
  end

  ir_update_a: assert property (
    @(posedge test_clk) disable iff (!debug_logic_reset_n)
    !$stable(irReg) && !firstEdge |->
      $past(tapState) inside {TAP_UPDATE_IR, TAP_RESET})
    else $error("instruction changed outside update-ir");

  chain_update_a: assert property (
    @(posedge test_clk) disable iff (!debug_logic_reset_n)
    !$stable(chainReg) && !firstEdge |->
      $past(tapState) == TAP_UPDATE_DR && $past(irReg) == INSTR_SCAN_N)
    else $error("chain number changed outside update-dr");

  out_enable_a: assert property (
    @(posedge test_clk) disable iff (!debug_logic_reset_n)
    serial_out_enable_n == !isShift)
    else $error("serial out enable does not match shifting");

  tms_reset_a: assert property (
    @(posedge test_clk) disable iff (!debug_logic_reset_n)
    debug_mode_select[*5] |=> tapState == TAP_RESET)
    else $error("five mode-select highs did not reach reset");

  update_idle_a: assert property (
    @(posedge test_clk) disable iff (!debug_logic_reset_n)
    tapState == TAP_UPDATE_DR && !debug_mode_select |=> tapState == TAP_IDLE)
    else $error("update-dr did not go to idle");

  id_capture_a: assert property (
    @(posedge test_clk) disable iff (!debug_logic_reset_n)
    tapState == TAP_CAPTURE_DR && irReg == INSTR_IDCODE |=>
      drShift == $past(id_value_input))
    else $error("id value not captured");

  relay_out_a: assert property (
    @(negedge test_clk) disable iff (!debug_logic_reset_n)
    tapState == TAP_SHIFT_DR && extRelay |=>
      ext_chain_shift_out == $past(debug_serial_in))
    else $error("external chain did not get serial data");

  hold_stable_a: assert property (
    @(posedge test_clk) disable iff (!debug_logic_reset_n)
    req != ackSync |=> $stable(hold))
    else $error("mirror word changed during handshake");

  mirror_take_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !$stable(tap_state_mirror) |-> $past(reqSync) != $past(ack))
    else $error("state mirror changed without a request");

endmodule : jdtp_port

`default_nettype wire

// File: jdtp_pkg.sv
package jdtp_pkg;

  // ****************************************************************
  // tap controller states, one fixed code per state
  // ****************************************************************
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h2,
    TAP_CAPTURE_DR = 4'h3,
    TAP_SHIFT_DR   = 4'h4,
    TAP_EXIT1_DR   = 4'h5,
    TAP_PAUSE_DR   = 4'h6,
    TAP_EXIT2_DR   = 4'h7,
    TAP_UPDATE_DR  = 4'h8,
    TAP_SEL_IR     = 4'h9,
    TAP_CAPTURE_IR = 4'hA,
    TAP_SHIFT_IR   = 4'hB,
    TAP_EXIT1_IR   = 4'hC,
    TAP_PAUSE_IR   = 4'hD,
    TAP_EXIT2_IR   = 4'hE,
    TAP_UPDATE_IR  = 4'hF
  } jdtp_state_e;

  // ****************************************************************
  // instruction codes and widths
  // ****************************************************************
  localparam int IR_W = 4;
  localparam int CHAIN_W = 5;
  localparam int ID_W = 32;
  localparam logic [3:0] INSTR_SCAN_N = 4'h2;
  localparam logic [3:0] INSTR_INTEST = 4'hC;
  localparam logic [3:0] INSTR_IDCODE = 4'hE;
  localparam logic [3:0] INSTR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [4:0] CHAIN_RESET_VAL = 5'h00;
  localparam logic [4:0] EXT_CHAIN_DEFAULT = 5'h04;

  // shift positions of each data register's input bit
  localparam logic [4:0] MSB_ID = 5'h1F;
  localparam logic [4:0] MSB_CHAIN = 5'h04;
  localparam logic [4:0] MSB_BYPASS = 5'h00;

endpackage : jdtp_pkg

// File: jdtp_debugger_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// debugger and one-bit external scan chain
// ****************************************************************
module jdtp_debugger_model (
  output logic test_clk,
  output logic debug_logic_reset_n,
  output logic debug_mode_select,
  output logic debug_serial_in,
  output logic ext_chain_shift_return,
  input wire logic debug_serial_out,
  input wire logic serial_out_enable_n,
  input wire logic ext_chain_shift_out
);
  initial
  begin
    test_clk = 1'b0;
    debug_logic_reset_n = 1'b1;
    debug_mode_select = 1'b1;
    debug_serial_in = 1'b0;
  end

  // the chain is a single stage clocked by the test clock; its return
  // stays low while the chain is held in reset
  always @(posedge test_clk or negedge debug_logic_reset_n)
    if (!debug_logic_reset_n)
      ext_chain_shift_return <= 1'b0;
    else
      ext_chain_shift_return <= ext_chain_shift_out;

  // clock stands low between frames; inputs change on the low phase
  task automatic step(input logic m, input logic d, output logic q,
    output logic oen);
    // inputs move just after the falling edge, clear of the relay sample
    #1;
    debug_mode_select = m;
    debug_serial_in = d;
    #39;
    test_clk = 1'b1;
    q = debug_serial_out;
    oen = serial_out_enable_n;
    #40;
    test_clk = 1'b0;
  endtask : step

  task automatic pump(input int n, input logic m);
    logic q;
    logic oen;
    repeat (n) step(m, 1'b0, q, oen);
  endtask : pump

  // from idle into shift, lsb first, ends parked in pause
  task automatic shift(input logic isIr, input int n, input logic [31:0] din,
    output logic [31:0] dout, output logic oeBad);
    logic q;
    logic oen;
    dout = '0;
    oeBad = 1'b0;
    step(1'b1, 1'b0, q, oen);
    if (isIr)
      step(1'b1, 1'b0, q, oen);
    step(1'b0, 1'b0, q, oen);
    step(1'b0, 1'b0, q, oen);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q, oen);
      dout[i] = q;
      oeBad = oeBad | oen;
    end
    step(1'b0, 1'b0, q, oen);
    oeBad = oeBad | !oen;
  endtask : shift

  task automatic finish();
    pump(2, 1'b1);
    pump(1, 1'b0);
  endtask : finish

  // released with the clock parked low, so no edge can race it
  task automatic tap_reset();
    debug_logic_reset_n = 1'b0;
    #200;
    debug_logic_reset_n = 1'b1;
  endtask : tap_reset
endmodule : jdtp_debugger_model

`default_nettype wire

// File: jdtp_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// testbench top
// ****************************************************************
module jdtp_port_tb_top
  import jdtp_pkg::*;
;
  // arbitrary id value
  localparam logic [31:0] ID_VAL = 32'h5A0F3C96;
  localparam logic [31:0] PAT = 32'hC3A596F0;
  logic coreClk;
  logic rstN;
  logic testClk, trstN, tms, tdi, chainRet, tdo, oeN, chainOut;
  logic [3:0] irMirror;
  logic [4:0] chainMirror;
  logic [3:0] stateMirror;
  int err_total;
  int checks_done;

  jdtp_port jdtp_port_inst (
    .core_clk(coreClk),
    .rst_n(rstN),
    .test_clk(testClk),
    .debug_logic_reset_n(trstN),
    .debug_mode_select(tms),
    .debug_serial_in(tdi),
    .ext_chain_shift_return(chainRet),
    .id_value_input(ID_VAL),
    .debug_serial_out(tdo),
    .serial_out_enable_n(oeN),
    .ext_chain_shift_out(chainOut),
    .tap_instruction_mirror(irMirror),
    .selected_chain_number(chainMirror),
    .tap_state_mirror(stateMirror)
  );

  jdtp_debugger_model jdtp_debugger_model_inst (
    .test_clk(testClk),
    .debug_logic_reset_n(trstN),
    .debug_mode_select(tms),
    .debug_serial_in(tdi),
    .ext_chain_shift_return(chainRet),
    .debug_serial_out(tdo),
    .serial_out_enable_n(oeN),
    .ext_chain_shift_out(chainOut)
  );

  initial coreClk = 1'b0;
  always #50 coreClk = ~coreClk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // the mirror handshake needs both clocks running for a few cycles
  task automatic mirrors(input logic m, input logic [3:0] ir,
    input logic [4:0] ch, input logic [3:0] st);
    jdtp_debugger_model_inst.pump(8, m);
    repeat (4) @(posedge coreClk);
    #1;
    chk(irMirror, ir);
    chk(chainMirror, ch);
    chk(stateMirror, st);
  endtask : mirrors

  task automatic test_idcode();
    logic [31:0] d;
    logic bad;
    jdtp_debugger_model_inst.pump(1, 1'b0);
    jdtp_debugger_model_inst.shift(1'b0, 32, PAT, d, bad);
    chk(d, ID_VAL);
    chk(bad, 0);
    jdtp_debugger_model_inst.finish();
    mirrors(1'b0, INSTR_IDCODE, 0, TAP_IDLE);
    $display("test idcode done");
  endtask : test_idcode

  task automatic test_scan_select();
    logic [31:0] d;
    logic bad;
    jdtp_debugger_model_inst.shift(1'b1, 4, INSTR_SCAN_N, d, bad);
    chk(d, IR_CAPTURE_VAL);
    mirrors(1'b0, INSTR_IDCODE, 0, TAP_PAUSE_IR);
    jdtp_debugger_model_inst.finish();
    mirrors(1'b0, INSTR_SCAN_N, 0, TAP_IDLE);
    jdtp_debugger_model_inst.shift(1'b0, 5, EXT_CHAIN_DEFAULT, d, bad);
    chk(d, CHAIN_RESET_VAL);
    chk(bad, 0);
    mirrors(1'b0, INSTR_SCAN_N, 0, TAP_PAUSE_DR);
    jdtp_debugger_model_inst.finish();
    mirrors(1'b0, INSTR_SCAN_N, EXT_CHAIN_DEFAULT, TAP_IDLE);
    $display("test scan select done");
  endtask : test_scan_select

  task automatic test_relay();
    logic [31:0] d;
    logic bad;
    jdtp_debugger_model_inst.shift(1'b1, 4, INSTR_INTEST, d, bad);
    jdtp_debugger_model_inst.finish();
    jdtp_debugger_model_inst.shift(1'b0, 32, PAT, d, bad);
    // two stages of lag: relay out, then chain stage
    chk(d[31:2], PAT[29:0]);
    chk(bad, 0);
    jdtp_debugger_model_inst.finish();
    mirrors(1'b0, INSTR_INTEST, EXT_CHAIN_DEFAULT, TAP_IDLE);
    $display("test relay done");
  endtask : test_relay

  task automatic test_tap_reset();
    logic [31:0] d;
    logic bad;
    jdtp_debugger_model_inst.shift(1'b1, 4, INSTR_BYPASS, d, bad);
    jdtp_debugger_model_inst.tap_reset();
    chk(oeN, 1);
    mirrors(1'b1, INSTR_IDCODE, CHAIN_RESET_VAL, TAP_RESET);
    $display("test tap reset done");
  endtask : test_tap_reset

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  initial
  begin
    err_total = 0;
    checks_done = 0;
    rstN = 1'b1;
    #5;
    rstN = 1'b0;
    repeat (10) @(posedge coreClk);
    #1;
    rstN = 1'b1;
    jdtp_debugger_model_inst.tap_reset();
    mirrors(1'b1, INSTR_IDCODE, CHAIN_RESET_VAL, TAP_RESET);
    test_idcode();
    test_scan_select();
    test_relay();
    test_tap_reset();
    report_and_stop();
  end

  // all tests need well under a millisecond
  initial
  begin
    #2000000;
    err_total++;
    report_and_stop();
  end
endmodule : jdtp_port_tb_top

`default_nettype wire
